/* include/bes_pkg.sv */
// Constants, command codes and register map of the bus exerciser sequencer
package bes_pkg;
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_TADDR = 12'h004;
  localparam logic [11:0] OFS_TDATA = 12'h008;
  localparam logic [11:0] OFS_BITSEL = 12'h00C;
  localparam logic [11:0] OFS_PROBE = 12'h010;
  localparam logic [11:0] OFS_START = 12'h014;
  localparam logic [11:0] OFS_STAT = 12'h018;
  localparam logic [11:0] OFS_RDATA = 12'h01C;
  localparam logic [11:0] OFS_STS = 12'h020;
  localparam logic [11:0] OFS_CTL = 12'h024;
  localparam logic [11:0] OFS_PRB_RES = 12'h028;
  localparam logic [11:0] OFS_PRB_SIG = 12'h02C;
  localparam logic [3:0] CMD_READ = 4'h1;
  localparam logic [3:0] CMD_WRITE = 4'h2;
  localparam logic [3:0] CMD_RAMP = 4'h3;
  localparam logic [3:0] CMD_ROTATING_BIT_PATTERN = 4'h4;
  localparam logic [3:0] CMD_AFLIP = 4'h5;
  localparam logic [3:0] CMD_DFLIP = 4'h6;
  localparam logic [3:0] CMD_STS = 4'h7;
  localparam logic [3:0] CMD_CTLWR = 4'h8;
  localparam logic [3:0] CMD_CTLFLIP = 4'h9;
  localparam logic [3:0] CMD_REPEAT = 4'hA;
  localparam logic [3:0] CMD_LOOP = 4'hB;
  localparam logic [3:0] CMD_STOP = 4'hC;
  localparam logic [3:0] CMD_RESUME = 4'hD;
  localparam logic [3:0] CMD_RUN = 4'hE;
  localparam logic [1:0] SYNC_FREE = 2'h0;
  localparam logic [1:0] SYNC_ADDR = 2'h1;
  localparam logic [1:0] SYNC_DATA = 2'h2;
  localparam logic [1:0] SYNC_SPECIAL = 2'h3;
  localparam logic [31:0] DEFAULT_START_ADDR = 32'h0000_0000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;
  typedef enum logic [1:0] {S_IDLE, S_LOCAL, S_WAIT, S_HALT} bes_state_t;
endpackage : bes_pkg

/* rtl/bes_sequencer.sv */
// Bus exerciser sequencer: APB registers, pod access sequencing, run control and probe
`timescale 1ns/1ps
`default_nettype none
module bes_sequencer import bes_pkg::*; #(
  parameter int DW = 8,
  parameter int NCTL = 8,
  parameter int NSTS = 16,
  parameter int FLASH_CYC = FLASH_HALF_CYC,
  parameter logic [31:0] DEFAULT_START = DEFAULT_START_ADDR
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Pod bus access
  output logic bus_req,
  output logic bus_we,
  output logic [31:0] bus_addr,
  output logic [DW-1:0] bus_wdata,
  input wire logic bus_done,
  input wire logic bus_err,
  input wire logic [DW-1:0] bus_rdata,
  // Target status and control lines
  input wire logic [NSTS-1:0] status_in,
  output logic [NCTL-1:0] ctl_out,
  // Run target
  output logic run_target_code,
  output logic [31:0] target_start_addr,
  // Operator indicators
  output logic looping_led,
  output logic stopped_led,
  output logic beep,
  // Probe and scope
  input wire logic sync_addr_valid,
  input wire logic sync_data_valid,
  input wire logic sync_special,
  input wire logic probe_tip,
  output logic probe_pulse_high,
  output logic probe_pulse_low,
  output logic scope_trigger
);

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    bes_state_t state;
    logic [3:0] op;
    logic [31:0] op_addr;
    logic [31:0] op_data;
    logic [4:0] op_bit;
    logic step;
    logic loop;
    logic err_loop;
    logic it_err;
    logic prev_err;
    logic beep;
    logic bus_req;
    logic bus_we;
    logic [31:0] bus_addr;
    logic [DW-1:0] bus_wdata;
    logic [31:0] taddr;
    logic [31:0] tdata;
    logic [4:0] bitsel;
    logic [1:0] sync_sel;
    logic stim_hi;
    logic stim_lo;
    logic use_start;
    logic [31:0] start_addr;
    logic [DW-1:0] rdata;
    logic [NSTS-1:0] sts;
    logic [NCTL-1:0] ctl;
    logic run;
    logic [31:0] tgt_start;
    logic [31:0] flash_cnt;
    logic flash;
    logic led_loop;
    logic led_stop;
    logic p_hi;
    logic p_lo;
    logic p_last;
    logic [15:0] p_cnt;
    logic [15:0] p_sig;
    logic stim_phase;
    logic pulse_hi;
    logic pulse_lo;
    logic scope;
  } bes_regs_t;

  bes_regs_t r;
  bes_regs_t n;
  logic cmd_go;
  logic [3:0] cmd;
  logic wr_acc;
  logic rd_acc;
  logic strobe;

  function automatic logic [DW-1:0] rotr(input logic [DW-1:0] x);
    rotr = {x[0], x[DW-1:1]};
  endfunction : rotr

  function automatic logic [DW-1:0] rotl(input logic [DW-1:0] x);
    rotl = {x[DW-2:0], x[DW-1]};
  endfunction : rotl

  function automatic logic [DW-1:0] dmask(input logic [4:0] b);
    dmask = {{(DW-1){1'b0}}, 1'b1} << b;
  endfunction : dmask

  function automatic logic [NCTL-1:0] cmask(input logic [4:0] b);
    cmask = {{(NCTL-1){1'b0}}, 1'b1} << b[2:0];
  endfunction : cmask

  // Start the latched operation from its first step
  function automatic bes_regs_t launch(input bes_regs_t s);
    bes_regs_t t;
    t = s;
    t.step = 1'b0;
    t.it_err = 1'b0;
    t.bus_addr = s.op_addr;
    t.bus_we = !(s.op == CMD_READ || s.op == CMD_AFLIP);
    t.bus_wdata = (s.op == CMD_RAMP) ? '0 : s.op_data[DW-1:0];
    if (s.op == CMD_STS || s.op == CMD_CTLWR || s.op == CMD_CTLFLIP) begin
      t.bus_req = 1'b0;
      t.state = S_LOCAL;
    end else begin
      t.bus_req = 1'b1;
      t.state = S_WAIT;
    end
    launch = t;
  endfunction : launch

  // End of one pass: rerun while looping, else go quiet
  function automatic bes_regs_t finish(input bes_regs_t s);
    bes_regs_t t;
    t = s;
    if (s.loop) begin
      t.beep = s.err_loop & s.prev_err & ~s.it_err;
      t.prev_err = s.it_err;
      t = launch(t);
    end else begin
      t.state = S_IDLE;
      t.bus_req = 1'b0;
    end
    finish = t;
  endfunction : finish

  assign wr_acc = psel && penable && r.pready && pwrite;
  assign rd_acc = psel && penable && r.pready && !pwrite;
  assign cmd = pwdata[3:0];
  assign cmd_go = wr_acc && (paddr == OFS_CMD);

  always_comb begin
    n = r;
    n.beep = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.pulse_hi = 1'b0;
    n.pulse_lo = 1'b0;
    strobe = 1'b1;
    // APB: one wait state, data and error prepared with pready
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr)
        OFS_CMD: n.prdata = {28'h0000000, r.op};
        OFS_TADDR: n.prdata = r.taddr;
        OFS_TDATA: n.prdata = r.tdata;
        OFS_BITSEL: n.prdata = {27'h0000000, r.bitsel};
        OFS_PROBE: n.prdata = {27'h0000000, r.use_start, r.stim_lo, r.stim_hi, r.sync_sel};
        OFS_START: n.prdata = r.start_addr;
        OFS_STAT: n.prdata = {26'h0000000, r.err_loop, r.run, r.led_stop | (r.state == S_IDLE),
                              r.loop, r.state == S_HALT, r.state != S_IDLE};
        OFS_RDATA: n.prdata = 32'(r.rdata);
        OFS_STS: n.prdata = 32'(r.sts);
        OFS_CTL: n.prdata = 32'(r.ctl);
        OFS_PRB_RES: n.prdata = {14'h0000, r.p_lo, r.p_hi, r.p_cnt};
        OFS_PRB_SIG: n.prdata = {16'h0000, r.p_sig};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (wr_acc) begin
      case (paddr)
        OFS_TADDR: n.taddr = pwdata;
        OFS_TDATA: n.tdata = pwdata;
        OFS_BITSEL: n.bitsel = pwdata[4:0];
        OFS_PROBE: begin
          n.sync_sel = pwdata[1:0];
          n.stim_hi = pwdata[2];
          n.stim_lo = pwdata[3];
          n.use_start = pwdata[4];
        end
        OFS_START: n.start_addr = pwdata;
        default: ;
      endcase
    end
    // Sequencer
    case (r.state)
      S_IDLE: begin
        if (cmd_go) begin
          if (cmd >= CMD_READ && cmd <= CMD_CTLFLIP) begin
            n.op = cmd;
            n.op_addr = r.taddr;
            n.op_data = r.tdata;
            n.op_bit = r.bitsel;
            n.loop = 1'b0;
            n.err_loop = 1'b0;
            n = launch(n);
          end else if (cmd == CMD_REPEAT && r.op != 4'h0) begin
            n = launch(n);
          end else if (cmd == CMD_LOOP && r.op != 4'h0) begin
            n.loop = 1'b1;
            n.err_loop = 1'b0;
            n.prev_err = 1'b0;
            n = launch(n);
          end else if (cmd == CMD_RUN) begin
            n.run = 1'b1;
            n.tgt_start = r.use_start ? r.start_addr : DEFAULT_START;
          end else if (cmd == CMD_STOP) begin
            n.run = 1'b0;
            n.loop = 1'b0;
            n.err_loop = 1'b0;
          end
        end
      end
      S_LOCAL: begin
        case (r.op)
          CMD_STS: n.sts = status_in;
          CMD_CTLWR: n.ctl = r.op_data[NCTL-1:0];
          default: n.ctl = r.ctl ^ cmask(r.op_bit);
        endcase
        n = finish(n);
        if (cmd_go && cmd == CMD_STOP) begin
          n.state = S_IDLE;
          n.loop = 1'b0;
        end
      end
      S_WAIT: begin
        if (cmd_go && cmd == CMD_STOP) begin
          n.state = S_IDLE;
          n.bus_req = 1'b0;
          n.loop = 1'b0;
          n.err_loop = 1'b0;
        end else if (bus_done) begin
          if (cmd_go && cmd == CMD_LOOP) begin
            n.loop = 1'b1;
          end
          if (bus_err && !r.err_loop) begin
            n.state = S_HALT;
            n.bus_req = 1'b0;
          end else begin
            if (bus_err) begin
              n.it_err = 1'b1;
            end
            case (r.op)
              CMD_RAMP: begin
                if (r.bus_wdata == '1) n = finish(n);
                else n.bus_wdata = r.bus_wdata + 1'b1;
              end
              CMD_ROTATING_BIT_PATTERN: begin
                if (r.bus_wdata == rotl(r.op_data[DW-1:0])) n = finish(n);
                else n.bus_wdata = rotr(r.bus_wdata);
              end
              CMD_AFLIP: begin
                n.rdata = bus_rdata;
                if (!r.step) begin
                  n.step = 1'b1;
                  n.bus_addr = r.bus_addr ^ (32'h0000_0001 << r.op_bit);
                end else n = finish(n);
              end
              CMD_DFLIP: begin
                if (!r.step) begin
                  n.step = 1'b1;
                  n.bus_wdata = r.bus_wdata ^ dmask(r.op_bit);
                end else n = finish(n);
              end
              CMD_READ: begin
                n.rdata = bus_rdata;
                n = finish(n);
              end
              default: n = finish(n);
            endcase
          end
        end else if (cmd_go && cmd == CMD_LOOP) begin
          n.loop = 1'b1;
        end
      end
      S_HALT: begin
        if (cmd_go && cmd == CMD_LOOP) begin
          n.loop = 1'b1;
          n.err_loop = 1'b1;
          n.prev_err = 1'b1;
          n = launch(n);
        end else if (cmd_go && cmd == CMD_RESUME) begin
          n.state = S_WAIT;
          n.bus_req = 1'b1;
        end else if (cmd_go && cmd == CMD_STOP) begin
          n.state = S_IDLE;
          n.loop = 1'b0;
        end
      end
      default: n.state = S_IDLE;
    endcase
    // Indicators
    if (r.flash_cnt == 32'(FLASH_CYC - 1)) begin
      n.flash_cnt = 32'h0000_0000;
      n.flash = !r.flash;
    end else begin
      n.flash_cnt = r.flash_cnt + 32'h0000_0001;
    end
    n.led_loop = r.flash & r.loop;
    n.led_stop = r.flash & !r.run & (r.state == S_IDLE || r.state == S_HALT);
    // Probe timing, stimulus and response
    case (r.sync_sel)
      SYNC_ADDR: strobe = sync_addr_valid;
      SYNC_DATA: strobe = sync_data_valid;
      SYNC_SPECIAL: strobe = sync_special;
      default: strobe = 1'b1;
    endcase
    n.scope = strobe;
    if (rd_acc && paddr == OFS_PRB_RES) begin
      n.p_hi = 1'b0;
      n.p_lo = 1'b0;
      n.p_cnt = 16'h0000;
      n.p_sig = 16'h0000;
    end
    if (strobe) begin
      n.p_hi = n.p_hi | probe_tip;
      n.p_lo = n.p_lo | !probe_tip;
      n.p_last = probe_tip;
      if (probe_tip != r.p_last) n.p_cnt = n.p_cnt + 16'h0001;
      n.p_sig = {n.p_sig[14:0], probe_tip ^ n.p_sig[15] ^ n.p_sig[11] ^ n.p_sig[8] ^ n.p_sig[6]};
      case ({r.stim_hi, r.stim_lo})
        2'b10: n.pulse_hi = 1'b1;
        2'b01: n.pulse_lo = 1'b1;
        2'b11: begin
          n.pulse_hi = !r.stim_phase;
          n.pulse_lo = r.stim_phase;
          n.stim_phase = !r.stim_phase;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r <= '0;
    else r <= n;
  end

  assign pready = r.pready;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign bus_req = r.bus_req;
  assign bus_we = r.bus_we;
  assign bus_addr = r.bus_addr;
  assign bus_wdata = r.bus_wdata;
  assign ctl_out = r.ctl;
  assign run_target_code = r.run;
  assign target_start_addr = r.tgt_start;
  assign looping_led = r.led_loop;
  assign stopped_led = r.led_stop;
  assign beep = r.beep;
  assign probe_pulse_high = r.pulse_hi;
  assign probe_pulse_low = r.pulse_lo;
  assign scope_trigger = r.scope;

  a_ramp_step: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == S_WAIT && r.op == CMD_RAMP && bus_done && !bus_err && r.bus_wdata != '1 && !cmd_go)
    |=> (bus_wdata == $past(bus_wdata) + 1'b1) && bus_req) else $error("ramp value did not advance");
  a_rotating_bit_pattern_rotate: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == S_WAIT && r.op == CMD_ROTATING_BIT_PATTERN && bus_done && !bus_err && !cmd_go &&
     r.bus_wdata != rotl(r.op_data[DW-1:0])) |=> bus_wdata == rotr($past(bus_wdata)))
    else $error("rotating_bit_pattern pattern did not rotate right");
  a_addr_flip: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == S_WAIT && r.op == CMD_AFLIP && !r.step && bus_done && !bus_err && !cmd_go)
    |=> bus_req && !bus_we && bus_addr == ($past(bus_addr) ^ (32'h0000_0001 << r.op_bit)))
    else $error("second read not at flipped address");
  a_data_flip: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == S_WAIT && r.op == CMD_DFLIP && !r.step && bus_done && !bus_err && !cmd_go)
    |=> bus_we && bus_addr == $past(bus_addr) && bus_wdata == ($past(bus_wdata) ^ dmask(r.op_bit)))
    else $error("second write not with flipped data");
  a_status_capture: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && cmd == CMD_STS && r.state == S_IDLE) |-> ##2 r.sts == $past(status_in))
    else $error("status inputs not captured");
  a_ctl_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && cmd == CMD_CTLFLIP && r.state == S_IDLE) |-> ##2 ctl_out == ($past(ctl_out, 2) ^ cmask(r.op_bit)))
    else $error("control line not toggled alone");
  a_error_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == S_WAIT && bus_done && bus_err && !r.err_loop && !cmd_go)
    |=> (r.state == S_HALT && !bus_req)[*2]) else $error("error did not halt activity");
  a_stop_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && cmd == CMD_STOP) |=> r.state == S_IDLE && !r.loop && !bus_req)
    else $error("stop did not reach quiescent state");
  a_run_start: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && cmd == CMD_RUN && r.state == S_IDLE) |=> run_target_code &&
    target_start_addr == ($past(r.use_start) ? $past(r.start_addr) : DEFAULT_START))
    else $error("run target start address wrong");

endmodule : bes_sequencer
`default_nettype wire

/* sim/bes_pod_model.sv */
// Pod bus responder that answers the sequencer's target accesses
`timescale 1ns/1ps
`default_nettype none
module bes_pod_model #(
  parameter int DW = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  input wire logic [DW-1:0] bus_wdata,
  // Pacing and fault injection
  input wire logic [3:0] wait_cyc,
  input wire logic err_on,
  input wire logic [DW-1:0] err_data,
  // Answer
  output logic bus_done,
  output logic bus_err,
  output logic [DW-1:0] bus_rdata
);
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      bus_done <= 1'b0;
      bus_err <= 1'b0;
      bus_rdata <= '0;
    end else begin
      bus_done <= 1'b0;
      bus_err <= 1'b0;
      // Unanswered data lines keep changing
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_done) begin
        if (cnt == wait_cyc) begin
          cnt <= 4'h0;
          bus_done <= 1'b1;
          bus_err <= err_on && (bus_wdata == err_data);
          bus_rdata <= bus_addr[DW-1:0] ^ {(DW/2){2'b10}};
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule : bes_pod_model
`default_nettype wire

/* sim/bus_exerciser_sequencer_test.sv */
// Self-checking bench for the bus exerciser sequencer
`timescale 1ns/1ps
`default_nettype none
module bus_exerciser_sequencer_test import bes_pkg::*;;
  typedef struct packed {logic [3:0] c; logic [31:0] a; logic [7:0] d; logic [4:0] b;} bes_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err_on = 1'b0, probe_tip = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, bus_addr, target_start_addr;
  logic pready, pslverr, pe, bus_req, bus_we, bus_done, bus_err, run_target_code;
  logic looping_led, stopped_led, beep, probe_pulse_high, probe_pulse_low, scope_trigger;
  logic [7:0] bus_wdata, bus_rdata, ctl_out, v, err_data = 8'h00;
  logic [15:0] status_in = 16'h0000;
  logic [2:0] syn = 3'b000;
  logic [3:0] pod_wait = 4'h0;
  int err_count = 0, n_tests = 0, n_beep = 0, n_hi = 0, n_lo = 0, n_trg = 0, n_loop = 0, n_stop = 0;
  logic [40:0] got[$], want[$];
  bes_row_t rows [7] = '{'{CMD_READ, 32'h0000_0200, 8'h00, 5'h00}, '{CMD_WRITE, 32'h0000_0100, 8'h5A, 5'h00},
    '{CMD_ROTATING_BIT_PATTERN, 32'h0000_0300, 8'h01, 5'h00}, '{CMD_ROTATING_BIT_PATTERN, 32'h0000_0304, 8'h96, 5'h00},
    '{CMD_AFLIP, 32'h0000_0400, 8'h00, 5'h1F}, '{CMD_AFLIP, 32'h8000_0401, 8'h00, 5'h00},
    '{CMD_DFLIP, 32'h0000_0500, 8'hF0, 5'h07}};
  bes_sequencer #(.DW(8), .NCTL(8), .NSTS(16), .FLASH_CYC(4), .DEFAULT_START(DEFAULT_START_ADDR)) u_bes_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_done(bus_done), .bus_err(bus_err), .bus_rdata(bus_rdata),
    .status_in(status_in), .ctl_out(ctl_out), .run_target_code(run_target_code),
    .target_start_addr(target_start_addr), .looping_led(looping_led), .stopped_led(stopped_led), .beep(beep),
    .sync_addr_valid(syn[0]), .sync_data_valid(syn[1]), .sync_special(syn[2]), .probe_tip(probe_tip),
    .probe_pulse_high(probe_pulse_high), .probe_pulse_low(probe_pulse_low), .scope_trigger(scope_trigger));
  bes_pod_model #(.DW(8)) u_bes_pod_model (.pclk(pclk), .presetn(presetn), .bus_req(bus_req),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .wait_cyc(pod_wait), .err_on(err_on), .err_data(err_data),
    .bus_done(bus_done), .bus_err(bus_err), .bus_rdata(bus_rdata));
  always #2 pclk = ~pclk;
  // Records pod accesses completed without error and counts indicator activity
  always @(posedge pclk) begin
    if (bus_req === 1'b1 && bus_done === 1'b1 && bus_err === 1'b0) got.push_back({bus_we, bus_addr, bus_we ? bus_wdata : 8'h00});
    n_beep += (beep === 1'b1);
    n_hi += (probe_pulse_high === 1'b1);
    n_lo += (probe_pulse_low === 1'b1);
    n_trg += (scope_trigger === 1'b1);
    n_loop += (looping_led === 1'b1);
    n_stop += (stopped_led === 1'b1);
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp_v);
    n_tests++;
    if (seen !== exp_v) begin
      err_count++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp_v);
    end
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) err_count++;
    rd = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [3:0] c);
    apb(1'b1, OFS_CMD, {28'h0, c});
  endtask : run
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && rd[1] !== 1'b1 && k < 1000);
    if (rd[0] !== 1'b0 && rd[1] !== 1'b1) err_count++;
  endtask : wait_idle
  task automatic build(input bes_row_t r);
    want = {};
    case (r.c)
      CMD_WRITE: want.push_back({1'b1, r.a, r.d});
      CMD_READ: want.push_back({1'b0, r.a, 8'h00});
      CMD_AFLIP: begin
        want.push_back({1'b0, r.a, 8'h00});
        want.push_back({1'b0, r.a ^ (32'h1 << r.b), 8'h00});
      end
      CMD_DFLIP: begin
        want.push_back({1'b1, r.a, r.d});
        want.push_back({1'b1, r.a, r.d ^ (8'h01 << r.b)});
      end
      default: begin
        v = r.d;
        want.push_back({1'b1, r.a, v});
        while (v !== {r.d[6:0], r.d[7]}) begin
          v = {v[0], v[7:1]};
          want.push_back({1'b1, r.a, v});
        end
      end
    endcase
  endtask : build
  task automatic cmp_q;
    chk(got.size(), want.size());
    foreach (want[i]) chk(got[i], want[i]);
    got = {};
  endtask : cmp_q
  initial begin
    cyc(40000);
    err_count++;
    end_sim;
  end
  initial begin
    cyc(16);
    presetn <= 1'b1;
    chk({bus_req, ctl_out, run_target_code}, 10'h000);
    apb(1'b0, 12'h030, 32'h0);
    chk({pe, rd}, {1'b1, 32'h0});
    foreach (rows[i]) begin
      apb(1'b1, OFS_TADDR, rows[i].a);
      apb(1'b1, OFS_TDATA, {24'h0, rows[i].d});
      apb(1'b1, OFS_BITSEL, {27'h0, rows[i].b});
      got = {};
      run(rows[i].c);
      wait_idle;
      build(rows[i]);
      cmp_q;
      apb(1'b0, OFS_RDATA, 32'h0);
      if (rows[i].c == CMD_READ) chk(rd, {24'h0, rows[i].a[7:0] ^ 8'hAA});
    end
    apb(1'b1, OFS_TADDR, 32'h0000_0700);
    run(CMD_REPEAT);
    wait_idle;
    cmp_q;
    pod_wait <= 4'h3;
    err_on <= 1'b1;
    err_data <= 8'h05;
    apb(1'b1, OFS_TADDR, 32'h0000_0600);
    run(CMD_RAMP);
    wait_idle;
    apb(1'b0, OFS_STAT, 32'h0);
    chk({rd[1], 32'(got.size())}, {1'b1, 32'h0000_0005});
    err_on <= 1'b0;
    run(CMD_RESUME);
    wait_idle;
    want = {};
    for (int k = 0; k < 256; k++) want.push_back({1'b1, 32'h0000_0600, k[7:0]});
    cmp_q;
    err_on <= 1'b1;
    err_data <= 8'h5A;
    apb(1'b1, OFS_TDATA, 32'h0000_005A);
    run(CMD_WRITE);
    wait_idle;
    run(CMD_LOOP);
    n_beep = 0;
    n_loop = 0;
    cyc(40);
    chk(n_loop > 0 && n_loop < 40, 1'b1);
    chk(n_beep, 0);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd[2], 1'b1);
    err_on <= 1'b0;
    cyc(40);
    chk(n_beep != 0, 1'b1);
    chk(got.size() > 1, 1'b1);
    run(CMD_STOP);
    cyc(4);
    got = {};
    n_stop = 0;
    cyc(40);
    chk({32'(got.size()), bus_req}, 33'h0);
    chk(n_stop > 0 && n_stop < 40, 1'b1);
    status_in <= 16'hA55A;
    run(CMD_STS);
    cyc(3);
    apb(1'b0, OFS_STS, 32'h0);
    chk(rd, 32'h0000_A55A);
    apb(1'b1, OFS_TDATA, 32'h0000_003C);
    run(CMD_CTLWR);
    cyc(3);
    chk(ctl_out, 8'h3C);
    v = 8'h3C;
    for (int b = 0; b < 8; b++) begin
      apb(1'b1, OFS_BITSEL, b);
      run(CMD_CTLFLIP);
      cyc(3);
      v[b] = ~v[b];
      chk(ctl_out, v);
    end
    apb(1'b1, OFS_START, 32'h0000_1234);
    apb(1'b1, OFS_PROBE, 32'h0000_0010);
    run(CMD_RUN);
    cyc(3);
    chk({run_target_code, target_start_addr}, {1'b1, 32'h0000_1234});
    run(CMD_STOP);
    cyc(3);
    chk(run_target_code, 1'b0);
    apb(1'b1, OFS_PROBE, 32'h0);
    run(CMD_RUN);
    cyc(3);
    chk(target_start_addr, DEFAULT_START_ADDR);
    run(CMD_STOP);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_PROBE, s << 2);
      cyc(2);
      n_hi = 0;
      n_lo = 0;
      cyc(40);
      chk({n_lo != 0, n_hi != 0}, s[1:0]);
    end
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, OFS_PROBE, s);
      cyc(2);
      n_trg = 0;
      syn <= 3'b001 << (s - 1);
      cyc(1);
      syn <= 3'b000;
      cyc(1);
      syn <= 3'b001 << (s % 3);
      cyc(1);
      syn <= 3'b000;
      cyc(4);
      chk(n_trg, 1);
    end
    apb(1'b1, OFS_PROBE, 32'h0);
    apb(1'b0, OFS_PRB_RES, 32'h0);
    probe_tip <= 1'b1;
    cyc(3);
    probe_tip <= 1'b0;
    cyc(3);
    apb(1'b0, OFS_PRB_RES, 32'h0);
    chk(rd[17:0], 18'h30002);
    apb(1'b0, OFS_PRB_RES, 32'h0);
    chk(rd[17:0], 18'h20000);
    run(CMD_RUN);
    cyc(2);
    chk(run_target_code, 1'b1);
    presetn <= 1'b0;
    cyc(2);
    chk({bus_req, ctl_out, run_target_code}, 10'h000);
    presetn <= 1'b1;
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd, 32'h0000_0008);
    end_sim;
  end
endmodule : bus_exerciser_sequencer_test
`default_nettype wire
